// File: logic/wait_cfg_pkg.sv
// wait_cfg_pkg: offsets, field layout, reset values and bus states for the
// area 0..3 program wait configuration block.
// assumes a 32-bit AXI4-Lite register bus and a 16-bit configuration word.
package wait_cfg_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int AREA_COUNT = 4;
    localparam int FIELD_W = 3;
    localparam int REG_W = 16;
    localparam int AREA_FIELD_STRIDE = 4;
    localparam int AREAS_PER_LANE = 2;
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int COUNT_W = AREA_COUNT * FIELD_W;

    // ------------------------------------------------------------------
    // field positions inside area_low_wait_control and the status word
    // ------------------------------------------------------------------
    localparam int AREA0_LSB = 0;
    localparam int AREA1_LSB = 4;
    localparam int AREA2_LSB = 8;
    localparam int AREA3_LSB = 12;
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_SEL_LSB = 16;

    // ------------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------------
    localparam logic [AXI_ADDR_W-1:0] WAIT_CTRL_OFFSET = 12'h000;
    localparam logic [AXI_ADDR_W-1:0] WAIT_STATUS_OFFSET = 12'h004;
    localparam logic [REG_W-1:0] WAIT_CTRL_RESET = 16'h7777;
    localparam logic [REG_W-1:0] RESERVED_MASK = 16'h8888;
    localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h7;
    localparam logic [FIELD_W-1:0] NO_WAIT = 3'h0;

    // ------------------------------------------------------------------
    // bus responses and channel states
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h0,
        WR_COMMIT = 2'h1,
        WR_RESP = 2'h3
    } wr_state_e;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_e;

endpackage : wait_cfg_pkg

// File: logic/wait_cfg_if.sv
// wait_cfg_if: bundle between the bus front end, the field bank and the
// wait applier; all parties run on one clock.
`timescale 1ns/1ps
interface wait_cfg_if;
    logic wr_en;
    logic [wait_cfg_pkg::REG_W-1:0] wr_data;
    logic [1:0] wr_strb;
    logic [wait_cfg_pkg::REG_W-1:0] cfg_value;
    logic [wait_cfg_pkg::AREA_COUNT-1:0] sel;
    logic [wait_cfg_pkg::COUNT_W-1:0] wait_count;

    modport bus (output wr_en, output wr_data, output wr_strb, output sel,
                 input cfg_value, input wait_count);
    modport bank (input wr_en, input wr_data, input wr_strb, output cfg_value);
    modport apply (input cfg_value, input sel, output wait_count);
endinterface : wait_cfg_if

// File: logic/wait_field_bank.sv
// wait_field_bank: storage of the four 3-bit wait fields.
// assumes wr_en is a one-cycle pulse from the bus front end.
`timescale 1ns/1ps
module wait_field_bank (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration bundle
    wait_cfg_if.bank cfg
);

    // ------------------------------------------------------------------
    // per-area fields
    // ------------------------------------------------------------------
    for (genvar i = 0; i < wait_cfg_pkg::AREA_COUNT; i++) begin : g_area
        localparam int LSB = i * wait_cfg_pkg::AREA_FIELD_STRIDE;
        logic [wait_cfg_pkg::FIELD_W-1:0] field_q;
        logic [wait_cfg_pkg::FIELD_W-1:0] field_d;

        always_comb begin
            field_d = field_q;
            // byte strobes honoured: areas 0,1 in lane 0, areas 2,3 in lane 1
            if (cfg.wr_en && cfg.wr_strb[i / wait_cfg_pkg::AREAS_PER_LANE]) begin
                field_d = cfg.wr_data[LSB +: wait_cfg_pkg::FIELD_W];
            end
        end

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                field_q <= wait_cfg_pkg::FIELD_RESET;
            end else begin
                field_q <= field_d;
            end
        end

        assign cfg.cfg_value[LSB +: wait_cfg_pkg::FIELD_W] = field_q;
        // reserved bit has no storage, so writes cannot reach it
        assign cfg.cfg_value[LSB + wait_cfg_pkg::FIELD_W] = 1'b0;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic seen_write_q;
    logic seen_write_d;

    always_comb begin
        seen_write_d = seen_write_q | cfg.wr_en;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            seen_write_q <= 1'b0;
        end else begin
            seen_write_q <= seen_write_d;
        end
    end

    area3_field_write_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en && cfg.wr_strb[1] |=>
        cfg.cfg_value[wait_cfg_pkg::AREA3_LSB +: wait_cfg_pkg::FIELD_W] ==
        $past(cfg.wr_data[wait_cfg_pkg::AREA3_LSB +: wait_cfg_pkg::FIELD_W]))
        else $error("area 3 field did not take written value");

    area2_field_write_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en && cfg.wr_strb[1] |=>
        cfg.cfg_value[wait_cfg_pkg::AREA2_LSB +: wait_cfg_pkg::FIELD_W] ==
        $past(cfg.wr_data[wait_cfg_pkg::AREA2_LSB +: wait_cfg_pkg::FIELD_W]))
        else $error("area 2 field did not take written value");

    area1_field_write_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en && cfg.wr_strb[0] |=>
        cfg.cfg_value[wait_cfg_pkg::AREA1_LSB +: wait_cfg_pkg::FIELD_W] ==
        $past(cfg.wr_data[wait_cfg_pkg::AREA1_LSB +: wait_cfg_pkg::FIELD_W]))
        else $error("area 1 field did not take written value");

    area0_field_write_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en && cfg.wr_strb[0] |=>
        cfg.cfg_value[wait_cfg_pkg::AREA0_LSB +: wait_cfg_pkg::FIELD_W] ==
        $past(cfg.wr_data[wait_cfg_pkg::AREA0_LSB +: wait_cfg_pkg::FIELD_W]))
        else $error("area 0 field did not take written value");

    reset_fields_a: assert property (@(posedge clock) disable iff (!nrst)
        !seen_write_q |-> cfg.cfg_value == wait_cfg_pkg::WAIT_CTRL_RESET)
        else $error("fields left reset value without a write");

endmodule : wait_field_bank

// File: logic/wait_apply.sv
// wait_apply: turns each area's field into the wait count that the bus cycle
// logic uses, gated by the area's three-state access select bit.
// assumes sel comes from a register on the same clock.
`timescale 1ns/1ps
module wait_apply (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration bundle
    wait_cfg_if.apply cfg
);

    for (genvar i = 0; i < wait_cfg_pkg::AREA_COUNT; i++) begin : g_area
        localparam int LSB = i * wait_cfg_pkg::AREA_FIELD_STRIDE;
        localparam int OUT = i * wait_cfg_pkg::FIELD_W;
        logic [wait_cfg_pkg::FIELD_W-1:0] count_q;
        logic [wait_cfg_pkg::FIELD_W-1:0] count_d;

        always_comb begin
            // field value is the cycle count itself, no decode needed
            count_d = cfg.cfg_value[LSB +: wait_cfg_pkg::FIELD_W];
            if (!cfg.sel[i]) begin
                count_d = wait_cfg_pkg::NO_WAIT;
            end
        end

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                count_q <= wait_cfg_pkg::NO_WAIT;
            end else begin
                count_q <= count_d;
            end
        end

        assign cfg.wait_count[OUT +: wait_cfg_pkg::FIELD_W] = count_q;
    end

    apply_selected_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.sel == 4'hf |=> cfg.wait_count ==
        {$past(cfg.cfg_value[14:12]), $past(cfg.cfg_value[10:8]),
         $past(cfg.cfg_value[6:4]), $past(cfg.cfg_value[2:0])})
        else $error("selected area count differs from its field");

    apply_unselected_a: assert property (@(posedge clock) disable iff (!nrst)
        !cfg.sel[3] && !cfg.sel[0] |=> cfg.wait_count[11:9] == 3'h0 &&
        cfg.wait_count[2:0] == 3'h0)
        else $error("unselected area got program wait cycles");

endmodule : wait_apply

// File: logic/area_wait_top.sv
// area_wait_top: AXI4-Lite slave holding the area 0..3 wait configuration
// and driving the per-area program wait counts.
// assumes area_sel comes from the select register on the same clock and
// that the bus master keeps one write and one read outstanding at most.
//
// Summary of operation
// - bits 14:12 hold area 3 wait count
// - bits 10:8 hold area 2 wait count
// - bits 6:4 hold area 1 wait count
// - bits 2:0 hold area 0 wait count
// - field equals cycle count; resets to seven
// - bits 15,11,7,3 read zero, ignore writes
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module area_wait_top (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // three-state access select bits, one per area
    input wire logic [3:0] area_sel,
    // program wait counts, 3 bits per area, area 0 lowest
    output logic [11:0] area_wait_count,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    wait_cfg_if cfg ();

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    wait_field_bank u_bank (
        .clock (clock),
        .nrst (nrst),
        .cfg (cfg.bank)
    );

    wait_apply u_apply (
        .clock (clock),
        .nrst (nrst),
        .cfg (cfg.apply)
    );

    assign cfg.sel = area_sel;
    assign area_wait_count = cfg.wait_count;

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    wait_cfg_pkg::wr_state_e wr_state_q;
    wait_cfg_pkg::wr_state_e wr_state_d;
    logic aw_got_q;
    logic aw_got_d;
    logic w_got_q;
    logic w_got_d;
    logic [11:0] waddr_q;
    logic [11:0] waddr_d;
    logic [15:0] wdata_q;
    logic [15:0] wdata_d;
    logic [1:0] wstrb_q;
    logic [1:0] wstrb_d;
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic waddr_ctrl;
    logic waddr_known;

    // address and data may come in either order or together
    always_comb begin
        wr_state_d = wr_state_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        case (wr_state_q)
            wait_cfg_pkg::WR_COLLECT: begin
                if (s_axi_awvalid && awready_q) begin
                    aw_got_d = 1'b1;
                    waddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q) begin
                    w_got_d = 1'b1;
                    wdata_d = s_axi_wdata[15:0];
                    wstrb_d = s_axi_wstrb[1:0];
                end
                if (aw_got_d && w_got_d) begin
                    wr_state_d = wait_cfg_pkg::WR_COMMIT;
                end
            end
            wait_cfg_pkg::WR_COMMIT: begin
                bvalid_d = 1'b1;
                bresp_d = waddr_known ? wait_cfg_pkg::RESP_OKAY : wait_cfg_pkg::RESP_SLVERR;
                wr_state_d = wait_cfg_pkg::WR_RESP;
            end
            wait_cfg_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wr_state_d = wait_cfg_pkg::WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = wait_cfg_pkg::WR_COLLECT;
                aw_got_d = 1'b0;
                w_got_d = 1'b0;
                bvalid_d = 1'b0;
            end
        endcase
        awready_d = (wr_state_d == wait_cfg_pkg::WR_COLLECT) && !aw_got_d;
        wready_d = (wr_state_d == wait_cfg_pkg::WR_COLLECT) && !w_got_d;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_state_q <= wait_cfg_pkg::WR_COLLECT;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 12'h000;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= wait_cfg_pkg::RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // low two address bits ignored: every register is one aligned word
    assign waddr_ctrl = waddr_q[11:2] == wait_cfg_pkg::WAIT_CTRL_OFFSET[11:2];
    // status word is read only; a write there is accepted and dropped
    assign waddr_known = waddr_ctrl || (waddr_q[11:2] == wait_cfg_pkg::WAIT_STATUS_OFFSET[11:2]);

    assign cfg.wr_en = (wr_state_q == wait_cfg_pkg::WR_COMMIT) && waddr_ctrl;
    assign cfg.wr_data = wdata_q & ~wait_cfg_pkg::RESERVED_MASK;
    assign cfg.wr_strb = wstrb_q;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    wait_cfg_pkg::rd_state_e rd_state_q;
    wait_cfg_pkg::rd_state_e rd_state_d;
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[wait_cfg_pkg::STATUS_COUNT_LSB +: wait_cfg_pkg::COUNT_W] = cfg.wait_count;
        status_word[wait_cfg_pkg::STATUS_SEL_LSB +: wait_cfg_pkg::AREA_COUNT] = area_sel;
    end

    always_comb begin
        rd_state_d = rd_state_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rd_state_q)
            wait_cfg_pkg::RD_IDLE: begin
                arready_d = 1'b1;
                if (s_axi_arvalid && arready_q) begin
                    arready_d = 1'b0;
                    rvalid_d = 1'b1;
                    rd_state_d = wait_cfg_pkg::RD_RESP;
                    rresp_d = wait_cfg_pkg::RESP_OKAY;
                    // reserved bits come back as zero from the bank itself
                    if (s_axi_araddr[11:2] == wait_cfg_pkg::WAIT_CTRL_OFFSET[11:2]) begin
                        rdata_d = {16'h0000, cfg.cfg_value};
                    end else if (s_axi_araddr[11:2] == wait_cfg_pkg::WAIT_STATUS_OFFSET[11:2]) begin
                        rdata_d = status_word;
                    end else begin
                        rdata_d = 32'h0000_0000;
                        rresp_d = wait_cfg_pkg::RESP_SLVERR;
                    end
                end
            end
            wait_cfg_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    arready_d = 1'b1;
                    rd_state_d = wait_cfg_pkg::RD_IDLE;
                end
            end
            default: begin
                rd_state_d = wait_cfg_pkg::RD_IDLE;
                rvalid_d = 1'b0;
                arready_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_state_q <= wait_cfg_pkg::RD_IDLE;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= wait_cfg_pkg::RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    reserved_read_a: assert property (@(posedge clock) disable iff (!nrst)
        s_axi_arvalid && arready_q &&
        s_axi_araddr[11:2] == wait_cfg_pkg::WAIT_CTRL_OFFSET[11:2] |=>
        rvalid_q && (rdata_q[15:0] & wait_cfg_pkg::RESERVED_MASK) == 16'h0000 &&
        rdata_q[15:0] == $past(cfg.cfg_value))
        else $error("control read returned wrong or reserved bits");

    write_resp_a: assert property (@(posedge clock) disable iff (!nrst)
        wr_state_q == wait_cfg_pkg::WR_COMMIT |=> bvalid_q ##1
        (bvalid_q || $past(s_axi_bready)) && $stable(bresp_q))
        else $error("write response missing or unstable");

    area3_count_a: assert property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en && wstrb_q[1] && area_sel[3] ##1 area_sel[3] |=>
        area_wait_count[11:9] == $past(wdata_q[14:12], 2))
        else $error("area 3 output count not the written field");

    cover_write_read_c: cover property (@(posedge clock) disable iff (!nrst)
        cfg.wr_en ##[1:20] (s_axi_rvalid && s_axi_rready));
    cover_unmapped_c: cover property (@(posedge clock) disable iff (!nrst)
        s_axi_rvalid && s_axi_rresp == wait_cfg_pkg::RESP_SLVERR);
    cover_sel_drop_c: cover property (@(posedge clock) disable iff (!nrst)
        $fell(area_sel[0]) ##1 area_wait_count[2:0] == 3'h0);

endmodule : area_wait_top

// File: verification/ext_area_model.sv
// ext_area_model: external area side that stretches each access by the
// program wait count the controller shows for the accessed area.
// assumes one access at a time, each started by a one-cycle acc_start.
`timescale 1ns/1ps
module ext_area_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // wait counts from the controller
    input wire logic [11:0] area_wait_count,
    // access request and result
    input wire logic acc_start,
    input wire logic [1:0] acc_area,
    output logic acc_done,
    output logic [2:0] acc_waits
);
    logic [2:0] cnt_q;
    logic busy_q;

    // count is taken at the start edge, later changes do not stretch a cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            acc_done <= 1'b0;
            acc_waits <= 3'h0;
        end else if (acc_start) begin
            cnt_q <= area_wait_count[3*acc_area +: 3];
            busy_q <= 1'b1;
            acc_done <= 1'b0;
            acc_waits <= 3'h0;
        end else if (busy_q && cnt_q == 3'h0) begin
            busy_q <= 1'b0;
            acc_done <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 3'h1;
            acc_waits <= acc_waits + 3'h1;
        end
    end
endmodule : ext_area_model

// File: verification/tb.sv
// tb: drives area_wait_top over axi4-lite and area_sel, compares with a model.
// assumes ext_area_model consumes the per-area wait counts.
`timescale 1ns/1ps
module tb;
    logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, acc_start, acc_done;
    logic [3:0] area_sel, wstrb;
    logic [11:0] area_wait_count, awaddr, araddr;
    logic [31:0] wdata, rdata, rng, d;
    logic [1:0] bresp, rresp, r, acc_area;
    logic [2:0] acc_waits;
    int miscompares, tests_run;
    int field[4];

    area_wait_top u_area_wait_top (.clock(clock), .nrst(nrst), .area_sel(area_sel),
        .area_wait_count(area_wait_count), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ext_area_model u_ext_area_model (.clock(clock), .nrst(nrst),
        .area_wait_count(area_wait_count), .acc_start(acc_start), .acc_area(acc_area),
        .acc_done(acc_done), .acc_waits(acc_waits));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // --------------------------------------------------------------------
    // model and reporting
    // --------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] exp_reg();
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 4; i++) v[4*i +: 3] = field[i][2:0];
        return v;
    endfunction : exp_reg

    // selected areas show their field, the rest show no wait
    function automatic logic [11:0] exp_cnt();
        logic [11:0] c;
        c = 12'h0;
        for (int i = 0; i < 4; i++) if (area_sel[i]) c[3*i +: 3] = field[i][2:0];
        return c;
    endfunction : exp_cnt

    task automatic results;
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic fail(input string m);
        miscompares++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask : fail

    task automatic hang;
        fail("wait limit");
        results();
    endtask : hang

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) fail("read data");
    endtask : cmp_data

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) fail("response code");
    endtask : cmp_resp

    task automatic cmp_count;
        repeat (2) @(posedge clock);
        @(negedge clock);
        tests_run++;
        if (area_wait_count !== exp_cnt()) fail("wait count");
        @(posedge clock);
    endtask : cmp_count

    // --------------------------------------------------------------------
    // bus tasks: enter and leave just after a rising edge
    // --------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        bit aw_hit, w_hit, ok;
        ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        repeat (40) begin
            @(negedge clock);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge clock);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            ok = (aw_hit || !awvalid) && (w_hit || !wvalid);
            if (ok) break;
        end
        if (!ok) hang();
        bready <= 1'b1;
        ok = 1'b0;
        repeat (40) begin
            @(negedge clock);
            ok = bvalid;
            r = bresp;
            @(posedge clock);
            if (ok) break;
        end
        if (!ok) hang();
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        bit ok;
        ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        repeat (40) begin
            @(negedge clock);
            ok = arready;
            @(posedge clock);
            if (ok) break;
        end
        if (!ok) hang();
        arvalid <= 1'b0;
        rready <= 1'b1;
        ok = 1'b0;
        repeat (40) begin
            @(negedge clock);
            ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ok) break;
        end
        if (!ok) hang();
        rready <= 1'b0;
    endtask : rd

    task automatic access(input int a);
        bit ok;
        logic [11:0] e;
        ok = 1'b0;
        acc_area <= a[1:0];
        acc_start <= 1'b1;
        @(posedge clock);
        acc_start <= 1'b0;
        repeat (12) begin
            @(negedge clock);
            ok = acc_done;
            if (ok) break;
        end
        if (!ok) hang();
        tests_run++;
        e = exp_cnt();
        if (acc_waits !== e[3*a +: 3]) fail("access wait cycles");
        @(posedge clock);
    endtask : access

    task automatic reset_dut;
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 4; i++) field[i] = 7;
    endtask : reset_dut

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, acc_start} = 6'h0;
        {awaddr, araddr, wdata, wstrb, acc_area} = 62'h0;
        area_sel = 4'hf;
        nrst = 1'b0;
        miscompares = 0;
        tests_run = 0;
        rng = 32'hd72c;
        reset_dut();
        rd(wait_cfg_pkg::WAIT_CTRL_OFFSET);
        cmp_data(d, exp_reg());
        cmp_count();
        // every code in every area, reserved and upper bits written as ones
        for (int v = 0; v < 8; v++) begin
            for (int i = 0; i < 4; i++) field[i] = (v + i) % 8;
            rng = xs(rng);
            area_sel <= rng[3:0];
            wr(wait_cfg_pkg::WAIT_CTRL_OFFSET, exp_reg() | 32'hffff8888, 4'hf);
            cmp_resp(r, wait_cfg_pkg::RESP_OKAY);
            rd(wait_cfg_pkg::WAIT_CTRL_OFFSET);
            cmp_data(d, exp_reg());
            cmp_count();
            for (int i = 0; i < 4; i++) access(i);
        end
        // random lane strobes
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            if (rng[16]) field[0] = rng[2:0];
            if (rng[16]) field[1] = rng[6:4];
            if (rng[17]) field[2] = rng[10:8];
            if (rng[17]) field[3] = rng[14:12];
            wr(wait_cfg_pkg::WAIT_CTRL_OFFSET, rng, {rng[19:18], rng[17:16]});
            rd(wait_cfg_pkg::WAIT_CTRL_OFFSET);
            cmp_data(d, exp_reg());
        end
        wr(12'h008, 32'h0, 4'hf);
        cmp_resp(r, wait_cfg_pkg::RESP_SLVERR);
        rd(12'h008);
        cmp_resp(r, wait_cfg_pkg::RESP_SLVERR);
        cmp_data(d, 32'h0);
        wr(wait_cfg_pkg::WAIT_STATUS_OFFSET, 32'h0, 4'hf);
        cmp_resp(r, wait_cfg_pkg::RESP_OKAY);
        rd(wait_cfg_pkg::WAIT_CTRL_OFFSET);
        cmp_data(d, exp_reg());
        // select off: no wait whatever the field holds
        area_sel <= 4'h0;
        cmp_count();
        access(3);
        rd(wait_cfg_pkg::WAIT_STATUS_OFFSET);
        cmp_data(d, 32'h0);
        area_sel <= 4'ha;
        cmp_count();
        rd(wait_cfg_pkg::WAIT_STATUS_OFFSET);
        cmp_data(d, {12'h0, area_sel, 4'h0, exp_cnt()});
        reset_dut();
        rd(wait_cfg_pkg::WAIT_CTRL_OFFSET);
        cmp_data(d, exp_reg());
        results();
    end
endmodule : tb
